// ===== design/fafu_defines.svh
// constants of the float add and abs-flags unit
`ifndef FAFU_DEFINES_SVH
`define FAFU_DEFINES_SVH

// operation codes and legal issue slots
`define FAFU_OP_ADD 8'h16
`define FAFU_OP_ABS_FLAGS 8'h74
`define FAFU_SLOT_LOW 3'h1
`define FAFU_SLOT_HIGH 3'h4
`define FAFU_LATENCY 3

// exception flag vector, same layout as in the status word
`define FAFU_FLAG_W 7
`define FAFU_BIT_DIVZERO 0
`define FAFU_BIT_INEXACT 1
`define FAFU_BIT_UNDERFLOW 2
`define FAFU_BIT_OVERFLOW 3
`define FAFU_BIT_INVALID 4
`define FAFU_BIT_IN_FLUSH 5
`define FAFU_BIT_OUT_FLUSH 6
`define FAFU_FLAGS_RESET 7'h00

// rounding modes
`define FAFU_RM_NEAREST 2'h0
`define FAFU_RM_ZERO 2'h1
`define FAFU_RM_UP 2'h2
`define FAFU_RM_DOWN 2'h3

// single-precision encodings
`define FAFU_EXP_MAX 8'hFF
`define FAFU_QNAN 32'hFFFFFFFF
`define FAFU_MAX_FINITE 31'h7F7FFFFF

`endif

// ===== design/fafu_pkg.sv
// types of the float add and abs-flags unit
`include "fafu_defines.svh"
`default_nettype none
package fafu_pkg;
    typedef struct packed {
        logic valid;
        logic [2:0] slot;
        logic [7:0] opcode;
        logic guard_present;
        logic [31:0] guard;
        logic [31:0] first_source_register;
        logic [31:0] second_source_register;
        logic [6:0] dest;
    } fafu_issue_t;

    typedef struct packed {
        logic valid;
        logic is_add;
        logic [6:0] dest;
        logic [31:0] a;
        logic [31:0] b;
        logic [1:0] rmode;
    } fafu_s1_t;

    typedef struct packed {
        logic valid;
        logic is_add;
        logic [6:0] dest;
        logic [31:0] data;
        logic [`FAFU_FLAG_W-1:0] flags;
    } fafu_s2_t;

    typedef struct packed {
        logic valid;
        logic [6:0] dest;
        logic [31:0] data;
    } fafu_wb_t;
endpackage
`default_nettype wire

// ===== design/fafu_adder.sv
// combinational single-precision adder with flush-to-zero
`include "fafu_defines.svh"
`default_nettype none
module fafu_adder (
    // operands and rounding mode
    input wire logic [31:0] a_i,
    input wire logic [31:0] b_i,
    input wire logic [1:0] rmode_i,
    // sum and exception vector
    output logic [31:0] sum_o,
    output logic [`FAFU_FLAG_W-1:0] flags_o
);
    function automatic logic [4:0] lead_zeros(input logic [27:0] v);
        lead_zeros = 5'h1C;
        for (int i = 0; i < 28; i++) begin
            if (v[i]) lead_zeros = 5'(27 - i);
        end
    endfunction

    logic a_nan, b_nan, a_snan, b_snan, a_inf, b_inf, swap, sub, lost;
    logic rs, inc, inexact_flag;
    logic [7:0] eg, es, d;
    logic [27:0] xa, xb, xg, xs, sh, raw, m;
    logic [4:0] lz;
    logic [24:0] rm;
    logic signed [9:0] e;

    always_comb begin
        flags_o = `FAFU_FLAGS_RESET;
        a_nan = a_i[30:23] == `FAFU_EXP_MAX && a_i[22:0] != 23'h000000;
        b_nan = b_i[30:23] == `FAFU_EXP_MAX && b_i[22:0] != 23'h000000;
        a_snan = a_nan && !a_i[22];
        b_snan = b_nan && !b_i[22];
        a_inf = a_i[30:23] == `FAFU_EXP_MAX && !a_nan;
        b_inf = b_i[30:23] == `FAFU_EXP_MAX && !b_nan;
        // denormal inputs become zero: no hidden bit and fraction dropped
        flags_o[`FAFU_BIT_IN_FLUSH] = (a_i[30:23] == 8'h00 &&
            a_i[22:0] != 23'h000000) || (b_i[30:23] == 8'h00 &&
            b_i[22:0] != 23'h000000); // [RQ10]
        xa = (a_i[30:23] == 8'h00) ? 28'h0000000 :
            {2'h1, a_i[22:0], 3'h0}; // [RQ10]
        xb = (b_i[30:23] == 8'h00) ? 28'h0000000 :
            {2'h1, b_i[22:0], 3'h0}; // [RQ10]
        swap = {b_i[30:23], xb} > {a_i[30:23], xa};
        eg = swap ? b_i[30:23] : a_i[30:23];
        es = swap ? a_i[30:23] : b_i[30:23];
        xg = swap ? xb : xa;
        xs = swap ? xa : xb;
        rs = swap ? b_i[31] : a_i[31];
        sub = a_i[31] ^ b_i[31];
        d = eg - es;
        sh = (d > 8'd27) ? 28'h0000000 : xs >> d;
        lost = (d > 8'd27) ? (xs != 28'h0000000) : ((sh << d) != xs);
        sh[0] = sh[0] | lost;
        raw = sub ? xg - sh : xg + sh; // [RQ8]
        e = $signed({2'h0, eg});
        lz = lead_zeros(raw);
        m = raw;
        if (raw[27]) begin
            m = {1'b0, raw[27:2], raw[1] | raw[0]};
            e = e + 10'sd1;
        end else if (raw != 28'h0000000) begin
            m = raw << (lz - 5'h01);
            e = e - $signed({5'h00, lz - 5'h01});
        end
        inexact_flag = |m[2:0];
        case (rmode_i) // [RQ9]
            `FAFU_RM_NEAREST: inc = m[2] & (m[1] | m[0] | m[3]);
            `FAFU_RM_ZERO: inc = 1'b0;
            `FAFU_RM_UP: inc = inexact_flag & !rs;
            `FAFU_RM_DOWN: inc = inexact_flag & rs;
            default: inc = 1'b0;
        endcase
        rm = {1'b0, m[26:3]} + {24'h000000, inc};
        sum_o = {rs, 8'h00, rm[22:0]};
        if (a_nan || b_nan || (a_inf && b_inf && sub)) begin
            sum_o = `FAFU_QNAN;
            flags_o[`FAFU_BIT_INVALID] = a_snan || b_snan ||
                (a_inf && b_inf); // [RQ12]
        end else if (a_inf || b_inf) begin
            sum_o = a_inf ? a_i : b_i;
        end else if (raw == 28'h0000000) begin
            // exact zero: sign follows IEEE, minus when both operands are negative or, for opposite signs, when rounding down
            sum_o = {(a_i[31] & b_i[31]) |
                (sub & (rmode_i == `FAFU_RM_DOWN)), 31'h00000000};
        end else if (e <= 10'sd0) begin
            // tiny results are flushed before rounding is considered
            sum_o = {rs, 31'h00000000}; // [RQ11]
            flags_o[`FAFU_BIT_OUT_FLUSH] = 1'b1; // [RQ11]
            flags_o[`FAFU_BIT_UNDERFLOW] = 1'b1; // [RQ12]
            flags_o[`FAFU_BIT_INEXACT] = 1'b1; // [RQ12]
        end else begin
            e = e + $signed({9'h000, rm[24]});
            flags_o[`FAFU_BIT_INEXACT] = inexact_flag; // [RQ12]
            if (e >= 10'sd255) begin
                flags_o[`FAFU_BIT_OVERFLOW] = 1'b1; // [RQ12]
                flags_o[`FAFU_BIT_INEXACT] = 1'b1; // [RQ12]
                if (rmode_i == `FAFU_RM_NEAREST ||
                    (rmode_i == `FAFU_RM_UP && !rs) ||
                    (rmode_i == `FAFU_RM_DOWN && rs)) begin
                    sum_o = {rs, `FAFU_EXP_MAX, 23'h000000};
                end else begin
                    sum_o = {rs, `FAFU_MAX_FINITE};
                end
            end else begin
                sum_o = {rs, e[7:0], rm[22:0]}; // [RQ8]
            end
        end
    end
endmodule
`default_nettype wire

// ===== design/fafu_unit.sv
// float alu slice: float add and abs-value flags, with sticky status flags
`include "fafu_defines.svh"
`default_nettype none
// Operation
// [RQ1] abs-flags opcode 116, one operand, latency three
// [RQ2] add opcode 22, two operands, latency three
// [RQ3] abs-flags writes exception vector of absolute value
// [RQ4] vector uses status word flag bit layout
// [RQ5] abs-flags never changes sticky status flags
// [RQ6] denormal abs-flags source sets input-flush bit
// [RQ7] abs-flags writes destination only if guard set
// [RQ8] add writes single-precision sum to destination
// [RQ9] add rounds by current status word mode
// [RQ10] denormal add inputs flushed, input-flush flag set
// [RQ11] denormal add result becomes zero, output-flush set
// [RQ12] add exceptions set matching status word flags
// [RQ13] flags sticky; only explicit status write clears
// [RQ14] flags update with the destination write
// [RQ15] simultaneous flag updates are ORed with old
// [RQ16] guarded-off add writes neither result nor flags
// [RQ17] unguarded operation is always enabled
module fafu_unit (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // issue from decode
    input wire fafu_pkg::fafu_issue_t issue_i,
    // processor status word fields
    input wire logic [1:0] rounding_mode_i,
    input wire logic status_write_i,
    input wire logic [`FAFU_FLAG_W-1:0] status_write_flags_i,
    input wire logic [`FAFU_FLAG_W-1:0] other_flag_set_i,
    // write-back and sticky flags
    output fafu_pkg::fafu_wb_t wb_o,
    output logic [`FAFU_FLAG_W-1:0] exception_flags_o
);
    fafu_pkg::fafu_s1_t s1_q, s1_d;
    fafu_pkg::fafu_s2_t s2_q, s2_d;
    fafu_pkg::fafu_wb_t wb_q, wb_d;
    logic [`FAFU_FLAG_W-1:0] flags_q, flags_d;
    logic [`FAFU_FLAG_W-1:0] add_flags, abs_flags;
    logic [31:0] add_sum;
    logic slot_ok, enabled, take_add, take_abs;

    fafu_adder u_adder (
        .a_i(s1_q.a),
        .b_i(s1_q.b),
        .rmode_i(s1_q.rmode),
        .sum_o(add_sum),
        .flags_o(add_flags)
    );

    // issue acceptance; other opcodes and slots belong to other units
    always_comb begin
        slot_ok = issue_i.slot == `FAFU_SLOT_LOW ||
            issue_i.slot == `FAFU_SLOT_HIGH; // [RQ1] [RQ2]
        enabled = !issue_i.guard_present || issue_i.guard[0]; // [RQ17]
        take_add = issue_i.valid && slot_ok && enabled &&
            issue_i.opcode == `FAFU_OP_ADD; // [RQ2] [RQ16]
        take_abs = issue_i.valid && slot_ok && enabled &&
            issue_i.opcode == `FAFU_OP_ABS_FLAGS; // [RQ1] [RQ7]
        s1_d.valid = take_add || take_abs;
        s1_d.is_add = take_add;
        s1_d.dest = issue_i.dest;
        s1_d.a = issue_i.first_source_register;
        // the single operand of abs-flags ignores the second source
        s1_d.b = take_add ? issue_i.second_source_register : 32'h00000000;
        s1_d.rmode = rounding_mode_i; // [RQ9]
    end

    // abs never rounds or overflows: only a signalling nan or a
    // denormal can raise anything
    always_comb begin
        abs_flags = `FAFU_FLAGS_RESET;
        abs_flags[`FAFU_BIT_IN_FLUSH] = s1_q.a[30:23] == 8'h00 &&
            s1_q.a[22:0] != 23'h000000; // [RQ6] [RQ4]
        abs_flags[`FAFU_BIT_INVALID] = s1_q.a[30:23] == `FAFU_EXP_MAX &&
            s1_q.a[22:0] != 23'h000000 && !s1_q.a[22]; // [RQ3] [RQ4]
        s2_d.valid = s1_q.valid;
        s2_d.is_add = s1_q.is_add;
        s2_d.dest = s1_q.dest;
        s2_d.data = s1_q.is_add ? add_sum :
            {{(32 - `FAFU_FLAG_W){1'b0}}, abs_flags}; // [RQ3] [RQ8]
        s2_d.flags = s1_q.is_add ? add_flags : `FAFU_FLAGS_RESET; // [RQ5]
    end

    // write-back and status flags move on the same edge
    always_comb begin
        wb_d.valid = s2_q.valid;
        wb_d.dest = s2_q.dest;
        wb_d.data = s2_q.data;
        // a set in the cycle of an explicit write survives that write
        flags_d = (status_write_i ? status_write_flags_i : flags_q) |
            other_flag_set_i; // [RQ13] [RQ15]
        if (s2_q.valid && s2_q.is_add) begin
            flags_d = flags_d | s2_q.flags; // [RQ12] [RQ14] [RQ5]
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            s1_q <= '0;
            s2_q <= '0;
            wb_q <= '0;
            flags_q <= `FAFU_FLAGS_RESET;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            wb_q <= wb_d;
            flags_q <= flags_d;
        end
    end

    assign wb_o = wb_q;
    assign exception_flags_o = flags_q;

    a_add_latency: assert property (@(posedge clk_i) // [RQ2]
        disable iff (reset_i)
        take_add |-> ##3 (wb_o.valid &&
        wb_o.dest == $past(issue_i.dest, 3)))
        else $error("add result not written three cycles after issue");

    a_abs_latency: assert property (@(posedge clk_i) // [RQ1]
        disable iff (reset_i)
        take_abs |-> ##3 (wb_o.valid &&
        wb_o.dest == $past(issue_i.dest, 3)))
        else $error("abs flags not written three cycles after issue");

    a_guard_off_quiet: assert property (@(posedge clk_i) // [RQ16] [RQ7]
        disable iff (reset_i)
        (issue_i.guard_present && !issue_i.guard[0] && !s1_q.valid &&
        !s2_q.valid) |-> ##3 !wb_o.valid)
        else $error("guarded-off operation wrote its destination");

    a_abs_denorm_flag: assert property (@(posedge clk_i) // [RQ6]
        disable iff (reset_i)
        (take_abs && issue_i.first_source_register[30:23] == 8'h00 &&
        issue_i.first_source_register[22:0] != 23'h000000)
        |-> ##3 wb_o.data == 32'h00000020)
        else $error("denormal abs source lost input flush bit");

    a_abs_normal_clean: assert property (@(posedge clk_i) // [RQ3]
        disable iff (reset_i)
        (take_abs && issue_i.first_source_register[30:23] != 8'h00 &&
        issue_i.first_source_register[30:23] != 8'hFF)
        |-> ##3 wb_o.data == 32'h00000000)
        else $error("finite abs source raised a flag");

    a_abs_no_status: assert property (@(posedge clk_i) // [RQ5]
        disable iff (reset_i)
        (s2_q.valid && !s2_q.is_add && !status_write_i &&
        other_flag_set_i == `FAFU_FLAGS_RESET)
        |=> exception_flags_o == $past(exception_flags_o))
        else $error("abs flags operation changed status flags");

    a_flags_sticky: assert property (@(posedge clk_i) // [RQ13]
        disable iff (reset_i)
        !status_write_i |=> (exception_flags_o &
        $past(exception_flags_o)) == $past(exception_flags_o))
        else $error("status flag cleared without explicit write");

    a_flags_or_merge: assert property (@(posedge clk_i) // [RQ15]
        disable iff (reset_i)
        1'b1 |=> (exception_flags_o & $past(other_flag_set_i)) ==
        $past(other_flag_set_i))
        else $error("simultaneous flag update was lost");

    a_flags_with_write: assert property (@(posedge clk_i) // [RQ14]
        disable iff (reset_i)
        (!$past(status_write_i) &&
        $past(other_flag_set_i) == `FAFU_FLAGS_RESET &&
        exception_flags_o != $past(exception_flags_o)) |-> wb_o.valid)
        else $error("status flags moved without a result write");

    a_add_in_flush: assert property (@(posedge clk_i) // [RQ10]
        disable iff (reset_i)
        (take_add && ((issue_i.first_source_register[30:23] == 8'h00 &&
        issue_i.first_source_register[22:0] != 23'h000000) ||
        (issue_i.second_source_register[30:23] == 8'h00 &&
        issue_i.second_source_register[22:0] != 23'h000000)))
        |-> ##3 exception_flags_o[`FAFU_BIT_IN_FLUSH])
        else $error("denormal add source left input flush clear");

    a_add_no_denorm: assert property (@(posedge clk_i) // [RQ11]
        disable iff (reset_i)
        (s2_q.valid && s2_q.is_add) |=> (wb_o.data[30:23] != 8'h00 ||
        wb_o.data[22:0] == 23'h000000))
        else $error("add wrote a denormal result");

    a_add_flags_set: assert property (@(posedge clk_i) // [RQ12] [RQ14]
        disable iff (reset_i)
        (s2_q.valid && s2_q.is_add) |=> (wb_o.valid &&
        (exception_flags_o & $past(s2_q.flags)) == $past(s2_q.flags)))
        else $error("add exception flags not set with its write");

    a_abs_snan_flag: assert property (@(posedge clk_i) // [RQ3] [RQ4]
        disable iff (reset_i)
        (take_abs && issue_i.first_source_register[30:23] == 8'hFF &&
        issue_i.first_source_register[22:0] != 23'h000000 &&
        !issue_i.first_source_register[22])
        |-> ##3 wb_o.data == 32'h00000010)
        else $error("signalling nan abs source lost invalid bit");

    a_abs_upper_zero: assert property (@(posedge clk_i) // [RQ3]
        disable iff (reset_i)
        take_abs |-> ##3 wb_o.data[31:`FAFU_FLAG_W] == 25'h0000000)
        else $error("abs flag vector has bits above the flag field");

    a_unguarded_take: assert property (@(posedge clk_i) // [RQ17]
        disable iff (reset_i)
        (issue_i.valid && !issue_i.guard_present &&
        (issue_i.slot == `FAFU_SLOT_LOW ||
        issue_i.slot == `FAFU_SLOT_HIGH) &&
        (issue_i.opcode == `FAFU_OP_ADD ||
        issue_i.opcode == `FAFU_OP_ABS_FLAGS)) |-> ##3 wb_o.valid)
        else $error("unguarded operation was not written back");

    a_slot_refused: assert property (@(posedge clk_i) // [RQ1] [RQ2]
        disable iff (reset_i)
        (issue_i.slot != `FAFU_SLOT_LOW &&
        issue_i.slot != `FAFU_SLOT_HIGH) |-> ##3 !wb_o.valid)
        else $error("operation from a foreign slot was written back");

    a_opcode_refused: assert property (@(posedge clk_i) // [RQ1] [RQ2]
        disable iff (reset_i)
        (issue_i.opcode != `FAFU_OP_ADD &&
        issue_i.opcode != `FAFU_OP_ABS_FLAGS) |-> ##3 !wb_o.valid)
        else $error("foreign operation code was written back");
endmodule
`default_nettype wire

// ===== bench/fafu_issue_model.sv
// issue-side model: offers one operation a cycle to the float unit
`default_nettype none
module fafu_issue_model (
    // clock
    input wire logic clk_i,
    // issue to the unit
    output var fafu_pkg::fafu_issue_t issue_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial issue_o = '0;
    task automatic offer(input fafu_pkg::fafu_issue_t op);
        @(negedge clk_i);
        issue_o <= op;
    endtask
    // idle lines carry the inverse of the last op, so stale fields never
    // look like a fresh request
    task automatic idle();
        @(negedge clk_i);
        issue_o <= {1'b0, ~issue_o[114:0]};
    endtask
endmodule
`default_nettype wire

// ===== bench/tb.sv
// bench of the float add and abs-flags unit
`include "fafu_defines.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {
        int due;
        logic [6:0] dest;
        logic [31:0] data;
        logic [6:0] fl;
    } fafu_note_t;
    localparam logic [7:0] ADD = `FAFU_OP_ADD;
    localparam logic [7:0] ABS = `FAFU_OP_ABS_FLAGS;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [1:0] rmode = 2'h0;
    logic sw = 1'b0;
    logic [6:0] swf = 7'h00;
    logic [6:0] oset = 7'h00;
    logic [6:0] flags;
    logic [6:0] exp_flags = 7'h00;
    fafu_pkg::fafu_issue_t issue;
    fafu_pkg::fafu_wb_t wb;
    fafu_note_t notes[$];
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;
    integer seed = 32'h84BB8AF8;
    fafu_unit dut_u (
        .clk_i(clk),
        .reset_i(reset),
        .issue_i(issue),
        .rounding_mode_i(rmode),
        .status_write_i(sw),
        .status_write_flags_i(swf),
        .other_flag_set_i(oset),
        .wb_o(wb),
        .exception_flags_o(flags)
    );
    fafu_issue_model model_u (.clk_i(clk), .issue_o(issue));
    initial forever #50 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp,
        input string what);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic cmp_flags(input logic [6:0] exp);
        n_tests++;
        if (flags !== exp) begin
            fails++;
            $display("ERROR %0t flags got %h exp %h", $time, flags, exp);
        end
    endtask
    // expected results are noted at issue, the watcher pops them
    task automatic op(input logic [7:0] code, input logic [2:0] slot,
        input logic gp, input logic g0, input logic [1:0] rm,
        input logic [31:0] a, input logic [31:0] b,
        input logic [31:0] res, input logic [6:0] fl);
        fafu_note_t n;
        logic [6:0] d;
        d = 7'($random(seed));
        // with no guard register the guard bit is noise and must not matter
        model_u.offer('{1'b1, slot, code, gp,
            {31'($random(seed)), gp ? g0 : 1'($random(seed))}, a, b, d});
        rmode = rm;
        if ((slot == `FAFU_SLOT_LOW || slot == `FAFU_SLOT_HIGH)
            && (code == ADD || code == ABS) && (!gp || g0)) begin
            n.due = cyc + `FAFU_LATENCY;
            n.dest = d;
            n.data = (code == ADD) ? res : {25'h0, fl};
            n.fl = (code == ADD) ? fl : 7'h00;
            notes.push_back(n);
        end
    endtask
    task automatic add(input logic [1:0] rm, input logic [31:0] a,
        input logic [31:0] b, input logic [31:0] res, input logic [6:0] fl);
        op(ADD, cyc[0] ? 3'h1 : 3'h4, 1'($random(seed)), 1'b1, rm, a, b,
            res, fl);
    endtask
    task automatic absf(input logic [31:0] a, input logic [6:0] vec);
        op(ABS, cyc[0] ? 3'h4 : 3'h1, 1'($random(seed)), 1'b1, 2'h0, a,
            32'($random(seed)), 32'h0, vec);
    endtask
    task automatic drain(input string name);
        model_u.idle();
        repeat (6) @(negedge clk);
        cmp_word(32'(notes.size()), 32'h0, "pending results");
        cmp_flags(exp_flags);
        $display("test %s done", name);
    endtask
    task automatic pulse(input logic w, input logic [6:0] wf,
        input logic [6:0] os, input logic [6:0] exp);
        @(negedge clk);
        sw = w;
        swf = wf;
        oset = os;
        @(negedge clk);
        sw = 1'b0;
        oset = 7'h00;
        exp_flags = exp;
        cmp_flags(exp);
    endtask
    always @(negedge clk) begin
        fafu_note_t n;
        if (!reset && wb.valid !== 1'b0) begin
            if (notes.size() == 0) begin
                fails++;
                $display("ERROR %0t unexpected write-back", $time);
            end else begin
                n = notes.pop_front();
                cmp_word(cyc, n.due, "latency");
                cmp_word(32'(wb.dest), 32'(n.dest), "dest");
                cmp_word(wb.data, n.data, "data");
                exp_flags = exp_flags | n.fl;
                cmp_flags(exp_flags);
            end
        end
    end
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #(3000 * 100);
        fails++;
        $display("ERROR %0t watchdog expired", $time);
        finish_test();
    end
    initial begin
        repeat (16) @(negedge clk);
        cmp_word(32'({wb.valid, wb.dest}), 32'h0, "reset write-back");
        cmp_word(wb.data, 32'h0, "reset data");
        cmp_flags(7'h00);
        reset = 1'b0;
        // back-to-back adds, nearest rounding
        add(2'h0, 32'hC0400000, 32'h3F800000, 32'hC0000000, 7'h00);
        add(2'h0, 32'h40400000, 32'hC0400000, 32'h00000000, 7'h00);
        add(2'h0, 32'h40400000, 32'h00800000, 32'h40400000, 7'h02);
        add(2'h0, 32'h40400000, 32'h00400000, 32'h40400000, 7'h20);
        add(2'h0, 32'h00C00000, 32'h80800000, 32'h00000000, 7'h46);
        add(2'h0, 32'h7F800000, 32'hFF800000, 32'hFFFFFFFF, 7'h10);
        add(2'h0, 32'h7F7FFFFF, 32'h7F7FFFFF, 32'h7F800000, 7'h0A);
        add(2'h0, 32'h00800000, 32'h00800000, 32'h01000000, 7'h00);
        drain("add table");
        add(2'h1, 32'h7F7FFFFF, 32'h7F7FFFFF, 32'h7F7FFFFF, 7'h0A);
        add(2'h2, 32'h40400000, 32'h00800000, 32'h40400001, 7'h02);
        add(2'h3, 32'h40400000, 32'h00800000, 32'h40400000, 7'h02);
        add(2'h3, 32'h7F7FFFFF, 32'h7F7FFFFF, 32'h7F7FFFFF, 7'h0A);
        add(2'h2, 32'hFF7FFFFF, 32'hFF7FFFFF, 32'hFF7FFFFF, 7'h0A);
        drain("rounding modes");
        pulse(1'b1, 7'h00, 7'h00, 7'h00);
        absf(32'h40400000, 7'h00);
        absf(32'hBF800000, 7'h00);
        absf(32'h00400000, 7'h20);
        absf(32'hFFFFFFFF, 7'h00);
        absf(32'hFFBFFFFF, 7'h10);
        absf(32'hFF7FFFFF, 7'h00);
        drain("abs flags");
        // none of these may write anything
        op(ADD, 3'h1, 1'b1, 1'b0, 2'h0, 32'h7F7FFFFF, 32'h7F7FFFFF, 32'h0,
            7'h0A);
        op(ABS, 3'h4, 1'b1, 1'b0, 2'h0, 32'h00400000, 32'h0, 32'h0,
            7'h20);
        op(ADD, 3'h2, 1'b0, 1'b1, 2'h0, 32'h7F800000, 32'hFF800000, 32'h0,
            7'h10);
        op(ABS, 3'h3, 1'b0, 1'b1, 2'h0, 32'hFFBFFFFF, 32'h0, 32'h0,
            7'h10);
        for (int i = 0; i < 4; i++) begin
            op(8'h80 | 8'($random(seed)), 3'h1, 1'b0, 1'b1, 2'h0,
                32'h7F7FFFFF, 32'h7F7FFFFF, 32'h0, 7'h0A);
        end
        drain("refused ops");
        pulse(1'b0, 7'h00, 7'h08, 7'h08);
        pulse(1'b1, 7'h01, 7'h04, 7'h05);
        add(2'h0, 32'h3F800000, 32'h3F800000, 32'h40000000, 7'h00);
        drain("sticky flags");
        pulse(1'b1, 7'h00, 7'h00, 7'h00);
        pulse(1'b0, 7'h00, 7'h40, 7'h40);
        reset = 1'b1;
        @(negedge clk);
        cmp_flags(7'h00);
        reset = 1'b0;
        exp_flags = 7'h00;
        add(2'h0, 32'h40400000, 32'h00400000, 32'h40400000, 7'h20);
        drain("second reset");
        finish_test();
    end
endmodule
`default_nettype wire
